// ---- core_perf_event_select.sv ----
`timescale 1ns/100ps

// Function
// - Event 0FH mask 01H counts retired loads with unknown-source miss.
// - Event 0FH mask 02H counts loads hitting modified sibling data.
// - Event 0FH mask 04H counts remote modified hits; two sockets only.
// - Event 0FH masks 10H, 20H, 80H count remote DRAM, other miss, I/O; 10H and 20H two sockets only.
// - Event 10H mask 01H counts legacy floating computational uops.
// - Event 10H masks 02H to 80H count vector uops by class.
// - Event 12H masks 01H to 40H count packed-integer operation classes.
// - Event 13H counts loads dispatched: bypass, delayed, buffered, all.
// - Blocked dispatch retries once from one-cycle staging latch; counted.
// - Event 14H mask 01H counts cycles with the divider busy.
// - Event 14H mask 02H counts multiplies except dot-product, multi-SAD.
// - Event 17H counts queue writes; 1EH counts cycles with any write.
// - Event 18H mask 01H counts instructions decodable only by decoder 0.
// - Event 19H mask 01H counts decodes producing exactly two uops.
// - Event 20H mask 01H counts loops that cannot stream from queue.
// - Event 24H masks 01H, 02H, 03H count unrejected L2 load hits, misses, both.
// - Event 24H masks 04H, 08H, 0CH count ownership requests.
// - Event 24H masks 10H, 20H, 30H count instruction fetch requests.
// - Event 24H masks 40H, 80H prefetches; AAH all misses; FFH all but rejected load hits.
// - Event 26H counts demand loads by line state invalid to modified.
module core_perf_event_select #(
  parameter int         COUNT_WIDTH = 48,
  parameter bit         TWO_SOCKET  = 1'b1
) (
  input  wire logic                clock,
  input  wire logic                nrst,
  // AXI4-Lite slave.
  input  wire logic [core_perf_event_select_pkg::ADDR_WIDTH-1:0] awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [core_perf_event_select_pkg::ADDR_WIDTH-1:0] araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  // Event strobes from the pipeline and caches.
  input  wire logic [7:0]          retiredLoadSource,
  input  wire logic [7:0]          floatUopClass,
  input  wire logic [6:0]          packedIntOps,
  input  wire logic                loadDispatch,
  input  wire logic                bypassOpen,
  input  wire logic                dividerBusy,
  input  wire logic                multiplyOp,
  input  wire logic                multiplyIsDotProduct,
  input  wire logic                multiplyIsMultiSad,
  input  wire logic [2:0]          iqWriteCount,
  input  wire logic                firstDecoderOnly,
  input  wire logic                dualUopDecode,
  input  wire logic                loopStreamOverflow,
  input  wire logic                l2Request,
  input  wire logic [1:0]          l2RequestKind,
  input  wire logic                l2Hit,
  input  wire logic                l2Rejected,
  input  wire logic                demandLoad,
  input  wire logic [1:0]          demandLineState,
  // Load dispatch results.
  output logic                     loadBypass,
  output logic                     loadBufferWrite
);
  import core_perf_event_select_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [3:0] popCount(input logic [7:0] bits);
    logic [3:0] total;
    total = 4'h0;
    for (int i = 0; i < 8; i++) begin
      total = total + {3'h0, bits[i]};
    end
    return total;
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strobe);
    logic [31:0] merged;
    merged = old;
    for (int i = 0; i < 4; i++) begin
      if (strobe[i]) begin
        merged[8*i +: 8] = data[8*i +: 8];
      end
    end
    return merged;
  endfunction

  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  logic [31:0]            ctrl;
  logic [COUNT_WIDTH-1:0] count;
  logic                   stagedLoad;
  logic                   delayedDispatch;
  logic                   lastMatch;
  logic [3:0]             lastIncrement;
  logic                   awHeld;
  logic                   wHeld;
  logic [ADDR_WIDTH-1:0]  writeAddr;
  logic [31:0]            writeData;
  logic [3:0]             writeStrobe;
  logic [ADDR_WIDTH-1:0]  readAddr;
  logic                   readPending;

  // ----------------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------------
  wire logic [7:0] eventSel  = ctrl[EVENT_LSB +: 8];
  wire logic [7:0] umask     = ctrl[UMASK_LSB +: 8];
  wire logic       edgeMode  = ctrl[EDGE_BIT];
  wire logic       enable    = ctrl[ENABLE_BIT];
  wire logic       invert    = ctrl[INVERT_BIT];
  wire logic [7:0] cmask     = ctrl[CMASK_LSB +: 8];

  // ----------------------------------------------------------------------
  // Load dispatch staging
  // ----------------------------------------------------------------------
  // A load that misses the bypass waits one cycle in the staging latch and
  // tries again; if the bypass is still closed it goes to the load buffer.
  wire logic directBypass   = loadDispatch & bypassOpen;
  wire logic retryBypass    = stagedLoad & bypassOpen;
  wire logic retryToBuffer  = stagedLoad & ~bypassOpen;
  wire logic next_staged    = loadDispatch & ~bypassOpen;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stagedLoad      <= 1'b0;
      delayedDispatch <= 1'b0;
      loadBypass      <= 1'b0;
      loadBufferWrite <= 1'b0;
    end else begin
      stagedLoad      <= next_staged;
      delayedDispatch <= stagedLoad;
      loadBypass      <= directBypass | retryBypass;
      loadBufferWrite <= retryToBuffer;
    end
  end

  // ----------------------------------------------------------------------
  // Event vectors, one bit per unit-mask bit
  // ----------------------------------------------------------------------
  wire logic [7:0] socketMask = TWO_SOCKET ? 8'hff : ~REMOTE_ONLY_MASK;
  wire logic [7:0] retiredVec = retiredLoadSource
                                & socketMask;

  wire logic [7:0] floatVec   = floatUopClass;
  wire logic [7:0] packedVec  = {1'b0, packedIntOps};

  // Bit 0 bypass, bit 1 delayed retry, bit 2 load buffer; 07H takes all.
  wire logic [7:0] dispatchVec = {5'h0, loadBufferWrite, delayedDispatch,
                                  loadBypass};

  wire logic mulCounted = multiplyOp & ~multiplyIsDotProduct
                          & ~multiplyIsMultiSad;
  wire logic [7:0] arithVec = {6'h0, mulCounted, dividerBusy};

  // Second-level requests: even bits hit, odd bits miss, two per kind.
  wire logic reqLoad   = l2Request & (l2RequestKind == REQ_LOAD);
  wire logic reqRfo    = l2Request & (l2RequestKind == REQ_RFO);
  wire logic reqFetch  = l2Request & (l2RequestKind == REQ_IFETCH);
  wire logic reqPref   = l2Request & (l2RequestKind == REQ_PREFETCH);
  wire logic [7:0] l2Vec = {
    reqPref & ~l2Hit,  reqPref & l2Hit,
    reqFetch & ~l2Hit, reqFetch & l2Hit,
    reqRfo & ~l2Hit,   reqRfo & l2Hit,
    reqLoad & ~l2Hit,  reqLoad & l2Hit & ~l2Rejected
  };

  wire logic [7:0] stateVec = demandLoad ?
                              (8'h01 << demandLineState) : 8'h00;

  // ----------------------------------------------------------------------
  // Event selection
  // ----------------------------------------------------------------------
  logic [3:0] increment;

  always_comb begin
    case (eventSel)
      EV_RETIRED_LOAD:  increment = popCount(retiredVec & umask);
      EV_FLOAT_UOPS:    increment = popCount(floatVec & umask);
      EV_PACKED_INT:    increment = popCount(packedVec & umask);
      EV_LOAD_DISPATCH: increment = popCount(dispatchVec & umask);
      EV_ARITH:         increment = popCount(arithVec & umask);
      EV_IQ_WRITES:     increment = umask[0] ?
                                    {1'b0, iqWriteCount} : 4'h0;
      EV_FIRST_DECODER: increment = 4'(umask[0] & firstDecoderOnly);
      EV_DUAL_UOP:      increment = {3'h0, umask[0] & dualUopDecode};
      EV_IQ_CYCLES:     increment = {3'h0, umask[0] &
                                    (iqWriteCount != 3'h0)};
      EV_LOOP_OVERFLOW: increment = 4'(umask[0] &
                                       loopStreamOverflow);
      EV_L2_REQUESTS:   increment = popCount(l2Vec & umask);
      EV_L2_DATA:       increment = popCount(stateVec & umask);
      default:          increment = 4'h0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Threshold, invert and edge
  // ----------------------------------------------------------------------
  // With a zero threshold the raw per-cycle total is added. Otherwise each
  // cycle is tested against the threshold; edge mode counts only the cycle
  // where the test turns true, which turns busy spans into occurrences.
  wire logic       meetsThreshold = {4'h0, increment} >= cmask;
  wire logic       match          = meetsThreshold ^ invert;
  wire logic       matchCounts    = edgeMode ? (match & ~lastMatch)
                                             : match;
  wire logic [3:0] step = (cmask == 8'h00) ? increment
                                           : {3'h0, matchCounts};

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire logic doWrite   = awHeld & wHeld & ~bvalid;
  wire logic hitCtrlW  = writeAddr == CTRL_OFFSET;
  wire logic hitLoW    = writeAddr == COUNT_LO_OFFSET;
  wire logic hitHiW    = writeAddr == COUNT_HI_OFFSET;
  wire logic hitStatW  = writeAddr == STATUS_OFFSET;
  wire logic writeOk   = hitCtrlW | hitLoW | hitHiW | hitStatW;

  logic [63:0] countWide;
  assign countWide = 64'(count);

  wire logic [31:0] loMerged = mergeBytes(countWide[31:0], writeData,
                                          writeStrobe);
  wire logic [31:0] hiMerged = mergeBytes(countWide[63:32], writeData,
                                          writeStrobe);
  wire logic [63:0] loadValue = hitLoW ? {countWide[63:32], loMerged}
                                       : {hiMerged, countWide[31:0]};

  wire logic [31:0] statusWord = {23'h0, stagedLoad, 1'b0, lastMatch,
                                  lastIncrement, TWO_SOCKET, enable};

  logic [31:0] readWord;
  logic        readOk;

  always_comb begin
    readOk = 1'b1;
    case (readAddr)
      CTRL_OFFSET:     readWord = ctrl;
      COUNT_LO_OFFSET: readWord = countWide[31:0];
      COUNT_HI_OFFSET: readWord = countWide[63:32];
      STATUS_OFFSET:   readWord = statusWord;
      default: begin
        readWord = 32'h0;
        readOk   = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Control and counter
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
    end else if (doWrite && hitCtrlW) begin
      ctrl <= mergeBytes(ctrl, writeData, writeStrobe) & CTRL_WRITE_MASK;
    end
  end

  // A software load wins over the increment of that same cycle.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (doWrite && (hitLoW || hitHiW)) begin
      count <= loadValue[COUNT_WIDTH-1:0];
    end else if (enable) begin
      count <= count + COUNT_WIDTH'(step);
    end
  end

  // Reprogramming restarts edge detection so a stale level is not an edge.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lastMatch     <= 1'b0;
      lastIncrement <= 4'h0;
    end else if (doWrite && hitCtrlW) begin
      lastMatch     <= 1'b1;
      lastIncrement <= 4'h0;
    end else begin
      lastMatch     <= match & enable;
      lastIncrement <= increment;
    end
  end

  // ----------------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      awready   <= 1'b0;
      awHeld    <= 1'b0;
      writeAddr <= '0;
    end else if (awvalid && awready) begin
      awready   <= 1'b0;
      awHeld    <= 1'b1;
      writeAddr <= {awaddr[ADDR_WIDTH-1:2], 2'h0};
    end else begin
      if (doWrite) begin
        awHeld <= 1'b0;
      end
      awready <= ~awHeld & ~bvalid;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wready      <= 1'b0;
      wHeld       <= 1'b0;
      writeData   <= 32'h0;
      writeStrobe <= 4'h0;
    end else if (wvalid && wready) begin
      wready      <= 1'b0;
      wHeld       <= 1'b1;
      writeData   <= wdata;
      writeStrobe <= wstrb;
    end else begin
      if (doWrite) begin
        wHeld <= 1'b0;
      end
      wready <= ~wHeld & ~bvalid;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp  <= writeOk ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Read channels
  // ----------------------------------------------------------------------
  // Data is captured a cycle after the address so counter reads see the
  // value after that cycle's increment, never a half-updated word.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      arready     <= 1'b0;
      readPending <= 1'b0;
      readAddr    <= '0;
    end else if (arvalid && arready) begin
      arready     <= 1'b0;
      readPending <= 1'b1;
      readAddr    <= {araddr[ADDR_WIDTH-1:2], 2'h0};
    end else begin
      if (readPending) begin
        readPending <= 1'b0;
      end
      arready <= ~readPending & ~rvalid;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= RESP_OKAY;
    end else if (readPending) begin
      rvalid <= 1'b1;
      rdata  <= readWord;
      rresp  <= readOk ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // core_perf_event_select

// ---- core_perf_event_select_pkg.sv ----
package core_perf_event_select_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFFSET      = 8'h00;
  localparam logic [7:0]  COUNT_LO_OFFSET  = 8'h04;
  localparam logic [7:0]  COUNT_HI_OFFSET  = 8'h08;
  localparam logic [7:0]  STATUS_OFFSET    = 8'h0c;
  localparam int          ADDR_WIDTH       = 8;

  // Control register fields.
  localparam int          EVENT_LSB        = 0;
  localparam int          UMASK_LSB        = 8;
  localparam int          EDGE_BIT         = 18;
  localparam int          ENABLE_BIT       = 22;
  localparam int          INVERT_BIT       = 23;
  localparam int          CMASK_LSB        = 24;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
  localparam logic [31:0] CTRL_WRITE_MASK  = 32'hffc4_ffff;

  // ----------------------------------------------------------------------
  // Event numbers
  // ----------------------------------------------------------------------
  localparam logic [7:0]  EV_RETIRED_LOAD  = 8'h0f;
  localparam logic [7:0]  EV_FLOAT_UOPS    = 8'h10;
  localparam logic [7:0]  EV_PACKED_INT    = 8'h12;
  localparam logic [7:0]  EV_LOAD_DISPATCH = 8'h13;
  localparam logic [7:0]  EV_ARITH         = 8'h14;
  localparam logic [7:0]  EV_IQ_WRITES     = 8'h17;
  localparam logic [7:0]  EV_FIRST_DECODER = 8'h18;
  localparam logic [7:0]  EV_DUAL_UOP      = 8'h19;
  localparam logic [7:0]  EV_IQ_CYCLES     = 8'h1e;
  localparam logic [7:0]  EV_LOOP_OVERFLOW = 8'h20;
  localparam logic [7:0]  EV_L2_REQUESTS   = 8'h24;
  localparam logic [7:0]  EV_L2_DATA       = 8'h26;

  // Retired-load sources that exist only with a second socket.
  localparam logic [7:0]  REMOTE_ONLY_MASK = 8'h34;

  // Second-level request kinds.
  localparam logic [1:0]  REQ_LOAD         = 2'h0;
  localparam logic [1:0]  REQ_RFO          = 2'h1;
  localparam logic [1:0]  REQ_IFETCH       = 2'h2;
  localparam logic [1:0]  REQ_PREFETCH     = 2'h3;

  // Bus responses.
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage

// ---- core_perf_event_select_checker.sv ----
`timescale 1ns/100ps
module core_perf_event_select_checker (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        loadDispatch,
  input wire logic        bypassOpen,
  input wire logic        loadBypass,
  input wire logic        loadBufferWrite
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------------
  // Load dispatch paths
  // ----------------------------------------------------------------------
  a_direct_bypass: assert property (
    loadDispatch && bypassOpen |=> loadBypass)
    else $error("open bypass did not pass the load");
  a_staged_retry: assert property (
    loadDispatch && !bypassOpen ##1 bypassOpen |=> loadBypass)
    else $error("staged load missed its second chance");
  a_staged_write: assert property (
    loadDispatch && !bypassOpen ##1 !bypassOpen |=> loadBufferWrite)
    else $error("staged load never reached the load buffer");
  a_buffer_cause: assert property (
    loadBufferWrite |-> $past(loadDispatch, 2) && !$past(bypassOpen, 2))
    else $error("load buffer written without a blocked dispatch");
  // ----------------------------------------------------------------------
  // Register bus timing
  // ----------------------------------------------------------------------
  a_b_latency: assert property (
    awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write response late or early");
  a_b_single: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  a_r_latency: assert property (arvalid && arready |=> !rvalid ##1 rvalid)
    else $error("read data late or early");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before taken");
  a_aw_pause: assert property (awvalid && awready |=> !awready)
    else $error("second write address taken at once");
  c_direct: cover property (loadDispatch && bypassOpen ##1 loadBypass);
  c_staged: cover property (loadBufferWrite);
  c_read: cover property (rvalid && rready);
endmodule // core_perf_event_select_checker

// ---- event_source_model.sv ----
`timescale 1ns/100ps
// Replays one pattern byte onto every strobe a cycle late, so a single
// pattern serves whichever event the counter has selected.
module event_source_model (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       fire,
  input  wire logic [7:0] mask,
  output logic      [7:0] retiredLoadSource,
  output logic      [7:0] floatUopClass,
  output logic      [6:0] packedIntOps,
  output logic            loadDispatch,
  output logic            bypassOpen,
  output logic            dividerBusy,
  output logic            multiplyOp,
  output logic            multiplyIsDotProduct,
  output logic            multiplyIsMultiSad,
  output logic      [2:0] iqWriteCount,
  output logic            firstDecoderOnly,
  output logic            dualUopDecode,
  output logic            loopStreamOverflow,
  output logic            l2Request,
  output logic      [1:0] l2RequestKind,
  output logic            l2Hit,
  output logic            l2Rejected,
  output logic            demandLoad,
  output logic      [1:0] demandLineState
);
  logic [7:0] pat;
  logic [7:0] live;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pat <= 8'h00;
    end else begin
      pat <= fire ? mask : 8'h00;
    end
  end
  // Gating by reset keeps every strobe quiet from time zero on.
  assign live = nrst ? pat : 8'h00;
  assign {retiredLoadSource, floatUopClass} = {live, live};
  assign packedIntOps = live[6:0];
  assign {loadDispatch, bypassOpen, dividerBusy, multiplyOp} =
    {live[0], live[1], live[0], live[0]};
  assign {multiplyIsDotProduct, multiplyIsMultiSad} = {live[2], live[3]};
  assign iqWriteCount = live[2:0];
  assign {firstDecoderOnly, dualUopDecode, loopStreamOverflow} = {3{live[0]}};
  assign {l2Request, l2RequestKind, l2Hit, l2Rejected} =
    {live[0], live[5:4], live[6], live[7]};
  assign {demandLoad, demandLineState} = {live[0], live[5:4]};
endmodule // event_source_model

// ---- core_perf_event_select_tb_top.sv ----
`timescale 1ns/100ps
module core_perf_event_select_tb_top;
  import core_perf_event_select_pkg::*;
  logic        clock, nrst, fire;
  logic [7:0]  awaddr, araddr, mask, retiredLoadSource, floatUopClass;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp, l2RequestKind, demandLineState;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, loadBypass;
  logic [6:0]  packedIntOps;
  logic [2:0]  iqWriteCount;
  logic        loadDispatch, bypassOpen, dividerBusy, multiplyOp, l2Hit;
  logic        multiplyIsDotProduct, multiplyIsMultiSad, firstDecoderOnly;
  logic        dualUopDecode, loopStreamOverflow, l2Request, l2Rejected;
  logic        demandLoad, loadBufferWrite;
  int          checks, num_errors;
  core_perf_event_select #(.COUNT_WIDTH(48), .TWO_SOCKET(1'b1)) dut (
    .clock, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .retiredLoadSource, .floatUopClass,
    .packedIntOps, .loadDispatch, .bypassOpen, .dividerBusy, .multiplyOp,
    .multiplyIsDotProduct, .multiplyIsMultiSad, .iqWriteCount,
    .firstDecoderOnly, .dualUopDecode, .loopStreamOverflow, .l2Request,
    .l2RequestKind, .l2Hit, .l2Rejected, .demandLoad, .demandLineState,
    .loadBypass, .loadBufferWrite);
  event_source_model src (.*);
  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r, input logic [3:0] s = 4'hf);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clock);
      if (awvalid && awready) begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    // The idle cycle keeps the next task from re-driving in this step.
    @(posedge clock);
  endtask
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic runCase(input logic [15:0] sel, input logic [7:0] pat,
                         input int n, input logic [31:0] exp,
                         input logic [7:0] tail = 8'h00,
                         input logic [15:0] upper = 16'h0040);
    axiWrite(CTRL_OFFSET, {upper, sel}, resp);
    axiWrite(COUNT_LO_OFFSET, 32'h0000_0000, resp);
    fire <= 1'b1;
    mask <= pat;
    repeat (n) @(posedge clock);
    mask <= tail;
    @(posedge clock);
    fire <= 1'b0;
    repeat (4) @(posedge clock);
    axiRead(COUNT_LO_OFFSET, rd, resp);
    check(rd, exp);
  endtask
  task stop_test;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    stop_test();
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, fire} = '0;
    {awaddr, araddr, wdata, wstrb, mask} = '0;
    checks = 0;
    num_errors = 0;
    nrst = 1'b0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    axiRead(CTRL_OFFSET, rd, resp);
    check(rd, CTRL_RESET);
    axiWrite(CTRL_OFFSET, 32'hffff_ffff, resp);
    check(32'(resp), 32'(RESP_OKAY));
    axiRead(CTRL_OFFSET, rd, resp);
    check(rd, CTRL_WRITE_MASK);
    axiWrite(CTRL_OFFSET, 32'h0000_0000, resp);
    axiWrite(COUNT_HI_OFFSET, 32'habcd_1234, resp, 4'h2);
    axiRead(COUNT_HI_OFFSET, rd, resp);
    check(rd, 32'h0000_1200);
    axiRead(COUNT_LO_OFFSET, rd, resp);
    check(rd, 32'h0000_0000);
    axiWrite(8'h10, 32'h0000_0001, resp);
    check(32'(resp), 32'(RESP_SLVERR));
    axiRead(8'h10, rd, resp);
    check(rd, 32'h0000_0000);
    check(32'(resp), 32'(RESP_SLVERR));
    runCase(16'h010f, 8'h01, 3, 32'h3);
    runCase(16'h020f, 8'h02, 2, 32'h2);
    runCase(16'h040f, 8'h04, 2, 32'h2);
    runCase(16'hb00f, 8'hff, 2, 32'h6);
    runCase(16'h0110, 8'h01, 3, 32'h3);
    runCase(16'hfe10, 8'hff, 2, 32'he);
    runCase(16'h7f12, 8'hff, 2, 32'he);
    runCase(16'h0713, 8'h03, 4, 32'h4);
    runCase(16'h0413, 8'h01, 1, 32'h1);
    runCase(16'h0213, 8'h01, 1, 32'h1);
    runCase(16'h0113, 8'h01, 1, 32'h1, 8'h02);
    runCase(16'h0114, 8'h01, 3, 32'h3);
    runCase(16'h0214, 8'h05, 2, 32'h0);
    runCase(16'h0214, 8'h01, 2, 32'h2);
    runCase(16'h0117, 8'h07, 2, 32'he);
    runCase(16'h011e, 8'h07, 3, 32'h3);
    runCase(16'h0118, 8'h01, 2, 32'h2);
    runCase(16'h0119, 8'h01, 2, 32'h2);
    runCase(16'h0120, 8'h01, 2, 32'h2);
    runCase(16'h0124, 8'h41, 2, 32'h2);
    runCase(16'h0124, 8'hc1, 2, 32'h0);
    runCase(16'h0324, 8'h01, 2, 32'h2);
    runCase(16'h0424, 8'h51, 2, 32'h2);
    runCase(16'h0c24, 8'h11, 2, 32'h2);
    runCase(16'h2024, 8'h21, 2, 32'h2);
    runCase(16'h3024, 8'h61, 2, 32'h2);
    runCase(16'h4024, 8'h71, 2, 32'h2);
    runCase(16'haa24, 8'h31, 2, 32'h2);
    runCase(16'hff24, 8'h41, 2, 32'h2);
    runCase(16'h0826, 8'h31, 2, 32'h2);
    runCase(16'h0226, 8'h21, 2, 32'h0);
    runCase(16'h0126, 8'h01, 2, 32'h2);
    runCase(16'h0114, 8'h01, 3, 32'h1, 8'h00, 16'h01c4);
    axiRead(STATUS_OFFSET, rd, resp);
    check(rd, 32'h0000_0043);
    check(32'(resp), 32'(RESP_OKAY));
    runCase(16'h0117, 8'h07, 4, 32'h4, 8'h00, 16'h0340);
    stop_test();
  end
endmodule // core_perf_event_select_tb_top
bind core_perf_event_select core_perf_event_select_checker chk (.*);
